// ---- common/spci_pkg.sv ----
package spci_pkg;
	// pin group widths
	localparam int ADDR_W = 12; // shared row/column address pins
	localparam int ROW_W = 12; // row address width
	localparam int COL_W = 8; // column address width
	localparam int BANK_W = 2; // bank select width
	localparam int NBANK = 4; // independent banks
	localparam int DATA_W = 32; // data lines
	localparam int MASK_W = 4; // one byte mask per byte lane
	localparam int BYTE_W = 8; // bits per byte lane
	localparam int WORDS_PER_BANK = 1048576; // words in each bank
	localparam int WORDS_TOTAL = NBANK * WORDS_PER_BANK; // whole array
	localparam int IDX_W = BANK_W + ROW_W + COL_W; // word index width
	localparam int LEN_W = 9; // burst length counter width
	localparam int AP_BIT = 10; // auto precharge bit on the address lines

	// mode register fields
	localparam int CL_LSB = 4; // read latency field
	localparam int CL_MSB = 6;
	localparam int BT_BIT = 3; // burst type, 1 = interleaved
	localparam int BL_LSB = 0; // burst length field
	localparam int BL_MSB = 2;
	localparam int WBL_BIT = 9; // single word writes
	localparam logic [2:0] CL_CODE_3 = 3'h3; // latency 3, anything else runs as 2
	localparam logic [2:0] BL_CODE_FULL = 3'h7; // full page code
	localparam logic [2:0] BL_CODE_MAX = 3'h3; // last power of two code
	localparam logic [LEN_W-1:0] LEN_ONE = 9'h001; // single beat
	localparam logic [LEN_W-1:0] LEN_FULL_PAGE = 9'h100; // 256 columns
	localparam logic [ADDR_W-1:0] MODE_RST = 12'h020; // latency 2, one beat, sequential

	// register map on the wishbone side
	localparam logic [7:0] REG_MODE = 8'h00; // mode register image, rw
	localparam logic [7:0] REG_STATUS = 8'h04; // device state, ro
	localparam logic [7:0] REG_REFCNT = 8'h08; // auto refresh count, write clears
	localparam int REFCNT_W = 16; // refresh counter width
	localparam int ST_PDOWN = 4; // status: power-down
	localparam int ST_SELF = 5; // status: self refresh
	localparam int ST_SUSP = 6; // status: clock suspended
	localparam int ST_BURST = 7; // status: burst running
	localparam int ST_CL3 = 8; // status: latency 3 selected

	// decoded pin commands
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_MRS,
		CMD_REF,
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_BST,
		CMD_PRE
	} spci_cmd_e;

	// strobe pattern to command, deselect reads as no-op
	function automatic spci_cmd_e spci_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		spci_cmd_e c;
		c = CMD_NOP;
		if (!cs_n) begin
			unique case ({ras_n, cas_n, we_n})
				3'h0: c = CMD_MRS;
				3'h1: c = CMD_REF;
				3'h2: c = CMD_PRE;
				3'h3: c = CMD_ACT;
				3'h4: c = CMD_WR;
				3'h5: c = CMD_RD;
				3'h6: c = CMD_BST;
				3'h7: c = CMD_NOP;
			endcase
		end
		return c;
	endfunction : spci_decode

	// burst length code to beats; reserved codes fall back to one beat
	function automatic logic [LEN_W-1:0] spci_burst_len(input logic [2:0] code,
		input logic ilv);
		logic [LEN_W-1:0] n;
		n = LEN_ONE;
		if (code <= BL_CODE_MAX)
			n = LEN_W'(LEN_ONE << code);
		else if (code == BL_CODE_FULL && !ilv)
			n = LEN_FULL_PAGE;
		return n;
	endfunction : spci_burst_len
endpackage : spci_pkg

// ---- src/spci_burst_seq.sv ----
`timescale 1ns/1ps
module spci_burst_seq
	import spci_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic run_i, // this edge is not suspended
	input wire logic start_i, // multi-beat column command taken
	input wire logic halt_i, // burst stop or a new column command
	input wire logic [COL_W-1:0] base_i, // starting column
	input wire logic [LEN_W-1:0] len_i, // beats in the burst
	input wire logic ilv_i, // interleaved order
	output logic active_o, // beats after the first still due
	output logic [COL_W-1:0] col_o, // column of the current beat
	output logic last_o // current beat is the final one
);
	logic [COL_W-1:0] base; // held start column
	logic [LEN_W-1:0] len; // held length
	logic [LEN_W-1:0] cnt; // beat number, the first beat is 0
	logic ilv; // held order
	logic [COL_W-1:0] mask; // low column bits that wrap
	logic [COL_W-1:0] step; // low bits before wrapping

	////////////////////////////////////////////////////////////////////////
	// wrap inside the burst; full page wraps on the whole column
	assign mask = COL_W'(len - LEN_ONE);
	assign step = ilv ? (base ^ cnt[COL_W-1:0]) : COL_W'(base + cnt[COL_W-1:0]);
	assign col_o = (base & ~mask) | (step & mask); // [R17]
	assign last_o = active_o && (cnt == len - LEN_ONE);

	////////////////////////////////////////////////////////////////////////
	// beat counter; frozen while the clock is suspended
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_o <= 1'b0;
			cnt <= '0;
			base <= '0;
			len <= LEN_ONE;
			ilv <= 1'b0;
		end else if (start_i) begin // new burst, beat 0 served by the caller
			active_o <= 1'b1;
			cnt <= LEN_ONE;
			base <= base_i;
			len <= len_i;
			ilv <= ilv_i;
		end else if (run_i && active_o) begin // [R3]
			if (halt_i || last_o)
				active_o <= 1'b0;
			cnt <= cnt + LEN_ONE;
		end
	end
endmodule : spci_burst_seq

// ---- src/spci_sdram_dev.sv ----
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// What this block and its controller must do
// R1 - every pin sampled on rising clock edge
// R2 - chip select high ignores commands
// R3 - low clock enable freezes next cycle
// R4 - controller raises enable before new command
// R5 - enable low when idle enters power-down
// R6 - twelve row, eight column bits shared
// R7 - bank select picks activated or accessed bank
// R8 - row strobe latches row address
// R9 - column strobe latches column address
// R10 - write strobe captures data from command
// R11 - byte mask blocks written byte
// R12 - byte mask floats read byte
// R13 - one 32-bit shared data bus
// R14 - four banks of 1048576 words
// R15 - mode set programs latency 2 or 3
// R16 - burst 1, 2, 4, 8 or page
// R17 - sequential or interleaved burst order
// R18 - burst reads with single word writes
// R19 - controller refreshes 4K rows per 64ms
// R20 - controller idles with no-op or deselect
// R21 - mask write now, read two later
// R22 - bank codes 0..3 map banks in order
// R23 - precharge with address bit ten hits all
// R24 - controller waits two cycles after mode set
module spci_sdram_dev
	import spci_pkg::*;
(
	input wire logic clk_i, // system clock, 20 MHz
	input wire logic rst_i, // synchronous reset, high
	input wire logic clk_en_i, // clock enable
	input wire logic chip_sel_n_i, // chip select, low
	input wire logic row_strobe_n_i, // row strobe, low
	input wire logic col_strobe_n_i, // column strobe, low
	input wire logic write_strobe_n_i, // write strobe, low
	input wire logic [ADDR_W-1:0] address_lines_i, // row/column/mode
	input wire logic [BANK_W-1:0] bank_select_i, // bank select
	input wire logic [MASK_W-1:0] byte_mask_i, // byte masks, high masks
	input wire logic [DATA_W-1:0] data_lines_i, // data pins, input side
	output logic [DATA_W-1:0] data_lines_o, // data pins, output side
	output logic [MASK_W-1:0] data_lines_oe_n_o, // per byte enable, low drives
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o // wishbone acknowledge
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	logic cke_q; // enable seen at the previous edge
	logic run; // this edge is live
	spci_cmd_e cmd; // decoded command of this edge
	logic [ADDR_W-1:0] mode_q; // mode register
	logic cl3; // latency 3 selected
	logic ilv; // interleaved burst order
	logic wbl; // single word writes
	logic [LEN_W-1:0] blen; // burst length in beats
	logic [NBANK-1:0] bank_open; // bank has an open row
	logic [ROW_W-1:0] open_row [NBANK]; // row held open per bank
	logic [BANK_W-1:0] cur_bank; // bank of the running burst
	logic cur_wr; // running burst writes
	logic cur_ap; // running burst closes its bank at the end
	logic col_cmd; // read or write to an open bank
	logic seq_start; // column command needs more beats
	logic seq_active; // later beats due
	logic seq_last; // current later beat is the final
	logic [COL_W-1:0] seq_col; // column of a later beat
	logic beat_on; // a data beat happens at this edge
	logic beat_wr; // that beat is a write
	logic [BANK_W-1:0] beat_bank; // bank of the beat
	logic [COL_W-1:0] beat_col; // column of the beat
	logic beat_ap; // beat belongs to an auto precharge access
	logic burst_end; // last beat of the access
	logic [IDX_W-1:0] idx; // word index of the beat
	logic [DATA_W-1:0] mem [WORDS_TOTAL]; // the array
	logic rd_v0; // read pipe stage one valid
	logic rd_v1; // read pipe stage two valid
	logic [DATA_W-1:0] rd_d0; // read pipe stage one data
	logic [DATA_W-1:0] rd_d1; // read pipe stage two data
	logic [MASK_W-1:0] mask_q; // byte masks one edge ago
	logic power_down; // idle with clock enable low
	logic self_ref; // self refresh entered
	logic [REFCNT_W-1:0] refcnt; // auto refresh commands seen
	logic wb_req; // bus request pending
	logic wb_wr; // bus write to the mode register takes effect now
	logic [31:0] status; // status word
	logic [IDX_W-1:0] chk_idx_q; // helper: index of the last beat
	logic [DATA_W-1:0] chk_word; // helper: word under the beat index

	////////////////////////////////////////////////////////////////////////
	// pin sampling: everything is taken on the rising edge only
	assign run = cke_q; // [R3]
	assign cmd = run ? spci_decode(chip_sel_n_i, row_strobe_n_i, col_strobe_n_i,
		write_strobe_n_i) : CMD_NOP; // [R1] [R2]
	assign cl3 = (mode_q[CL_MSB:CL_LSB] == CL_CODE_3); // [R15]
	assign ilv = mode_q[BT_BIT]; // [R17]
	assign wbl = mode_q[WBL_BIT]; // [R18]
	assign blen = spci_burst_len(mode_q[BL_MSB:BL_LSB], ilv); // [R16]

	// clock enable history; a low enable stalls the next edge
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cke_q <= 1'b1;
		else
			cke_q <= clk_en_i; // [R3]
	end

	////////////////////////////////////////////////////////////////////////
	// column access decode; accesses to a closed bank are dropped
	assign col_cmd = (cmd == CMD_RD || cmd == CMD_WR) && bank_open[bank_select_i]; // [R7] [R9]
	// single word writes never start the sequencer
	assign seq_start = col_cmd && (blen != LEN_ONE) && !(cmd == CMD_WR && wbl); // [R18]
	assign beat_on = col_cmd || (seq_active && run);
	assign beat_wr = col_cmd ? (cmd == CMD_WR) : cur_wr; // [R10]
	assign beat_bank = col_cmd ? bank_select_i : cur_bank;
	assign beat_col = col_cmd ? address_lines_i[COL_W-1:0] : seq_col; // [R6]
	assign beat_ap = col_cmd ? address_lines_i[AP_BIT] : cur_ap;
	assign burst_end = (col_cmd && !seq_start) || (!col_cmd && run && seq_last);
	assign idx = {beat_bank, open_row[beat_bank], beat_col}; // [R14]
	assign chk_word = mem[idx];

	// later beats of a burst
	spci_burst_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.start_i(seq_start),
		.halt_i(cmd == CMD_BST || col_cmd),
		.base_i(address_lines_i[COL_W-1:0]),
		.len_i(blen),
		.ilv_i(ilv),
		.active_o(seq_active),
		.col_o(seq_col),
		.last_o(seq_last)
	);

	// context of the running access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_bank <= '0;
			cur_wr <= 1'b0;
			cur_ap <= 1'b0;
		end else if (col_cmd) begin
			cur_bank <= bank_select_i; // [R7]
			cur_wr <= (cmd == CMD_WR);
			cur_ap <= address_lines_i[AP_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank state: activate, precharge, auto precharge at burst end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_open <= '0;
			for (int b = 0; b < NBANK; b++)
				open_row[b] <= '0;
		end else begin
			if (cmd == CMD_ACT) begin // [R8] [R22]
				bank_open[bank_select_i] <= 1'b1;
				open_row[bank_select_i] <= address_lines_i[ROW_W-1:0];
			end else if (cmd == CMD_PRE) begin
				if (address_lines_i[AP_BIT])
					bank_open <= '0; // [R23]
				else
					bank_open[bank_select_i] <= 1'b0;
			end else if (burst_end && beat_ap) begin
				bank_open[beat_bank] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array write; a masked byte keeps its old value
	always_ff @(posedge clk_i) begin
		if (beat_on && beat_wr) begin // [R10] [R13]
			for (int b = 0; b < MASK_W; b++) begin
				if (!byte_mask_i[b]) // [R11] [R21]
					mem[idx][b*BYTE_W +: BYTE_W] <= data_lines_i[b*BYTE_W +: BYTE_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read pipe; depth two covers latency 3, latency 2 taps stage one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_v0 <= 1'b0;
			rd_v1 <= 1'b0;
			rd_d0 <= '0;
			rd_d1 <= '0;
		end else if (run) begin // [R3]
			rd_v0 <= beat_on && !beat_wr;
			rd_d0 <= chk_word;
			rd_v1 <= rd_v0;
			rd_d1 <= rd_d0;
		end
	end

	// masks are delayed one edge so the output stage sees them two late
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mask_q <= '1;
		else
			mask_q <= byte_mask_i; // [R2] [R21]
	end

	// output stage; drives only valid, unmasked byte lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_lines_o <= '0;
			data_lines_oe_n_o <= '1;
		end else if (run) begin
			data_lines_o <= cl3 ? rd_d1 : rd_d0; // [R15]
			data_lines_oe_n_o <= {MASK_W{!(cl3 ? rd_v1 : rd_v0)}} | mask_q; // [R12] [R13]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power-down and self refresh; both leave as soon as enable rises
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_down <= 1'b0;
			self_ref <= 1'b0;
		end else if (clk_en_i) begin
			power_down <= 1'b0;
			self_ref <= 1'b0;
		end else if (cmd == CMD_REF) begin
			self_ref <= 1'b1;
		end else if (run && !seq_active && !rd_v0 && !rd_v1) begin
			power_down <= 1'b1; // [R5]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode register; a pin mode set beats a bus write in the same edge
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign wb_wr = wb_req && wb_we_i && wb_ack_o && (wb_adr_i == REG_MODE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= MODE_RST;
		end else if (cmd == CMD_MRS && bank_open == '0) begin
			mode_q <= address_lines_i; // [R15]
		end else if (wb_wr) begin
			if (wb_sel_i[0])
				mode_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				mode_q[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
		end
	end

	// refresh counter; a new refresh wins over a clearing write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			refcnt <= '0;
		else if (cmd == CMD_REF && clk_en_i && bank_open == '0)
			refcnt <= refcnt + REFCNT_W'(1);
		else if (wb_req && wb_we_i && wb_ack_o && wb_adr_i == REG_REFCNT)
			refcnt <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave; ack one cycle after the request, data with it
	always_comb begin
		status = '0;
		status[NBANK-1:0] = bank_open;
		status[ST_PDOWN] = power_down;
		status[ST_SELF] = self_ref;
		status[ST_SUSP] = !cke_q;
		status[ST_BURST] = seq_active;
		status[ST_CL3] = cl3;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			unique case (wb_adr_i)
				REG_MODE: wb_dat_o <= {{(32-ADDR_W){1'b0}}, mode_q};
				REG_STATUS: wb_dat_o <= status;
				REG_REFCNT: wb_dat_o <= {{(32-REFCNT_W){1'b0}}, refcnt};
				default: wb_dat_o <= '0; // unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge clk_i) begin
		chk_idx_q <= idx;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_rd3_cmd;
		(cmd == CMD_RD) && col_cmd && cl3 && clk_en_i;
	endsequence
	sequence s_rd3_open;
		s_rd3_cmd ##1 (clk_en_i && byte_mask_i == '0);
	endsequence

	property p_cs_ignore;
		(run && chip_sel_n_i && !seq_active) |=> $stable(bank_open);
	endproperty
	a_cs_ignore: assert property (p_cs_ignore) else $error("deselected edge changed banks"); // [R2]

	property p_suspend;
		!clk_en_i |-> ##2 ($stable(data_lines_o) && $stable(data_lines_oe_n_o)
			&& $stable(bank_open));
	endproperty
	a_suspend: assert property (p_suspend) else $error("state moved while suspended"); // [R3]

	property p_pdown;
		(run && !clk_en_i && cmd != CMD_REF && !seq_active && !rd_v0 && !rd_v1)
			|=> power_down;
	endproperty
	a_pdown: assert property (p_pdown) else $error("idle low enable missed power-down"); // [R5]

	property p_row;
		(cmd == CMD_ACT) |=> (bank_open[$past(bank_select_i)]
			&& open_row[$past(bank_select_i)] == $past(address_lines_i));
	endproperty
	a_row: assert property (p_row) else $error("row not latched into bank"); // [R8]

	property p_mrs;
		(cmd == CMD_MRS && bank_open == '0) |=> (mode_q == $past(address_lines_i));
	endproperty
	a_mrs: assert property (p_mrs) else $error("mode set not stored"); // [R15]

	property p_rd_cl2;
		((cmd == CMD_RD) && col_cmd && !cl3 && clk_en_i && byte_mask_i == '0)
			|-> ##2 (data_lines_oe_n_o == '0);
	endproperty
	a_rd_cl2: assert property (p_rd_cl2) else $error("latency 2 read not driven"); // [R15]

	property p_rd_cl3;
		s_rd3_open |-> ##2 (data_lines_oe_n_o == '0);
	endproperty
	a_rd_cl3: assert property (p_rd_cl3) else $error("latency 3 read not driven"); // [R15]

	property p_rd_mask;
		(clk_en_i && byte_mask_i[0]) |-> ##2 data_lines_oe_n_o[0];
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("masked read byte driven"); // [R12]

	property p_wr_mask;
		(beat_on && beat_wr && byte_mask_i[0])
			|=> (mem[chk_idx_q][BYTE_W-1:0] == $past(chk_word[BYTE_W-1:0]));
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("masked write byte stored"); // [R11]

	property p_pre_all;
		(cmd == CMD_PRE && address_lines_i[AP_BIT]) |=> (bank_open == '0);
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open"); // [R23]

	property p_single_wr;
		((cmd == CMD_WR) && col_cmd && wbl) |=> !seq_active;
	endproperty
	a_single_wr: assert property (p_single_wr) else $error("single write started a burst"); // [R18]

	property p_wb_ack;
		(wb_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle");
endmodule : spci_sdram_dev

// ---- tb/spci_ctrl_model.sv ----
`timescale 1ns/1ps
// controller stand-in: issues pin commands and resolves the shared data lines
module spci_ctrl_model
	import spci_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic [DATA_W-1:0] dev_dq_i, // device data out
	input wire logic [MASK_W-1:0] dev_oe_n_i, // device lane enables, low drives
	output logic cke_o, // clock enable
	output logic cs_n_o, // chip select, low
	output logic [2:0] cmd_o, // row, column, write strobes
	output logic [ADDR_W-1:0] adr_o, // address lines
	output logic [BANK_W-1:0] ba_o, // bank select
	output logic [MASK_W-1:0] dqm_o, // byte masks
	output logic [DATA_W-1:0] dq_o // resolved data lines
);
	logic [DATA_W-1:0] wd; // write data while driving
	logic drv; // controller owns the lines
	logic [DATA_W-1:0] pat; // undriven lines toggle so no stale word survives
	initial begin
		{cke_o, cs_n_o, cmd_o} = 5'h1f; // enable high, idle no-op
		{adr_o, ba_o, dqm_o, wd, drv} = '0;
		pat = 32'h5a5a_c3c3;
	end
	always @(posedge clk_i) pat <= ~pat;
	// each lane: device if it drives, else controller, else floating pattern
	always_comb begin
		for (int i = 0; i < MASK_W; i++) begin
			dq_o[i*BYTE_W+:BYTE_W] = !dev_oe_n_i[i] ? dev_dq_i[i*BYTE_W+:BYTE_W] :
				drv ? wd[i*BYTE_W+:BYTE_W] : pat[i*BYTE_W+:BYTE_W];
		end
	end
	// one command for one edge, then back to no-op
	task cmd(input logic cs, input logic [2:0] c, input logic [ADDR_W-1:0] a,
		input logic [BANK_W-1:0] b, input logic [MASK_W-1:0] m, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		{cs_n_o, cmd_o, adr_o, ba_o, dqm_o, wd, drv} <= {cs, c, a, b, m, d, c == 3'h4};
		@(posedge clk_i);
		{cs_n_o, cmd_o, dqm_o, drv} <= {4'hf, 4'h0, 1'b0}; // idle as no-op
	endtask : cmd
	// enable low for one edge; high again a cycle before any command
	task suspend;
		cke_o <= 1'b0;
		@(posedge clk_i);
		cke_o <= 1'b1;
	endtask : suspend
endmodule : spci_ctrl_model

// ---- tb/spci_sdram_dev_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, (a), (e)); end end
module spci_sdram_dev_tb
	import spci_pkg::*;
;
	typedef struct packed {logic [1:0] b; logic [7:0] c; logic [31:0] d; logic [3:0] m;} spci_row_s;
	// bank, column, data, write mask; bank 0 columns 0..3 feed the burst tests
	spci_row_s rows [10] = '{'{2'h0, 8'h00, 32'h11111111, 4'h0},
		'{2'h0, 8'h01, 32'h22222222, 4'h0}, '{2'h0, 8'h02, 32'h33333333, 4'h0},
		'{2'h0, 8'h03, 32'h44444444, 4'h0}, '{2'h1, 8'hff, 32'hdeadbeef, 4'h5},
		'{2'h2, 8'h10, 32'hcafef00d, 4'ha}, '{2'h3, 8'h80, 32'h89abcdef, 4'hf},
		'{2'h1, 8'h00, 32'h55555555, 4'h0}, '{2'h2, 8'h01, 32'h66666666, 4'h0},
		'{2'h3, 8'h02, 32'h77777777, 4'h0}};
	logic clk_i; // system clock
	logic rst_i; // reset, high
	logic wb_cyc, wb_stb, wb_we; // bus request
	logic [7:0] wb_adr; // bus address
	logic [3:0] wb_sel; // bus byte selects
	logic [31:0] wb_dat, wb_q, dq, data_lines_o; // bus and pin data
	logic [31:0] wb_dat_o;
	logic wb_ack_o, cke, cs_n;
	logic [2:0] cmd;
	logic [11:0] adr;
	logic [1:0] ba;
	logic [3:0] dqm, oe_n;
	int n_mismatch, checks_done, cycles;
	always #25 clk_i = ~clk_i;
	spci_ctrl_model ctrl (.clk_i(clk_i), .dev_dq_i(data_lines_o), .dev_oe_n_i(oe_n),
		.cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .adr_o(adr), .ba_o(ba), .dqm_o(dqm), .dq_o(dq));
	spci_sdram_dev dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(cke), .chip_sel_n_i(cs_n),
		.row_strobe_n_i(cmd[2]), .col_strobe_n_i(cmd[1]), .write_strobe_n_i(cmd[0]),
		.address_lines_i(adr), .bank_select_i(ba), .byte_mask_i(dqm), .data_lines_i(dq),
		.data_lines_o(data_lines_o), .data_lines_oe_n_o(oe_n), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lanes(input logic [3:0] m);
		for (int i = 0; i < 4; i++) lanes[i*8+:8] = {8{m[i]}};
	endfunction : lanes
	// classic cycle; request held until ack is sampled high
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, 4'hf, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_q = wb_dat_o;
		{wb_cyc, wb_stb} <= 2'b00;
	endtask : wb
	// read, then check every beat and the release after the last one
	task rd(input logic [1:0] b, input logic [7:0] c, input logic [3:0] m, input int lat,
		input int nb, input logic ilv, input logic [31:0] e);
		logic [7:0] k;
		logic [31:0] x;
		ctrl.cmd(1'b0, 3'h5, {4'h0, c}, b, m, 32'h0);
		repeat (lat - 1) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			#1;
			k = ilv ? (c ^ i[7:0]) : ((c + i[7:0]) & 8'h03);
			x = (nb > 1) ? 32'h11111111 * (k + 8'h01) : e;
			`CHK(oe_n, m)
			`CHK(data_lines_o & ~lanes(m), x & ~lanes(m))
			@(posedge clk_i);
		end
		#1 `CHK(oe_n, 4'hf)
	endtask : rd
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// hang guard, well above the roughly 190 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = {2'b01, 47'h0};
		{n_mismatch, checks_done, cycles} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 `CHK(oe_n, 4'hf)
		wb(1'b0, REG_MODE, 32'h0);
		`CHK(wb_q[11:0], MODE_RST)
		wb(1'b0, 8'hfc, 32'h0);
		`CHK(wb_q, 32'h0)
		$display("reset test done");
		// same row in every bank, then the table
		for (int b = 0; b < 4; b++) ctrl.cmd(1'b0, 3'h3, 12'h0ab, b[1:0], 4'h0, 32'h0);
		foreach (rows[i]) begin
			ctrl.cmd(1'b0, 3'h4, {4'h0, rows[i].c}, rows[i].b, 4'h0, 32'h0);
			ctrl.cmd(1'b0, 3'h4, {4'h0, rows[i].c}, rows[i].b, rows[i].m, rows[i].d);
			rd(rows[i].b, rows[i].c, 4'h0, 2, 1, 1'b0, rows[i].d & ~lanes(rows[i].m));
		end
		$display("table test done");
		rd(2'h0, 8'h02, 4'h1, 2, 1, 1'b0, 32'h33333333);
		ctrl.cmd(1'b1, 3'h4, 12'h002, 2'h0, 4'h0, 32'h0);
		rd(2'h0, 8'h02, 4'h0, 2, 1, 1'b0, 32'h33333333);
		// enable low right after a read stretches its beat by one cycle
		ctrl.cmd(1'b0, 3'h5, 12'h003, 2'h0, 4'h0, 32'h0);
		ctrl.suspend();
		#1 `CHK(oe_n, 4'h0)
		@(posedge clk_i);
		#1 `CHK(data_lines_o, 32'h44444444)
		`CHK(oe_n, 4'h0)
		@(posedge clk_i);
		#1 `CHK(oe_n, 4'hf)
		// enable held low while idle: power-down shows in the status word
		ctrl.cke_o <= 1'b0;
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK(wb_q[ST_SUSP:ST_PDOWN], 3'h5)
		ctrl.cke_o <= 1'b1;
		$display("mask and suspend test done");
		// refresh counts only once every bank is closed
		ctrl.cmd(1'b0, 3'h2, 12'h400, 2'h1, 4'h0, 32'h0);
		ctrl.cmd(1'b0, 3'h1, 12'h000, 2'h0, 4'h0, 32'h0);
		wb(1'b0, REG_REFCNT, 32'h0);
		`CHK(wb_q[15:0], 16'h0001)
		ctrl.cmd(1'b0, 3'h0, 12'h030, 2'h0, 4'h0, 32'h0);
		repeat (2) @(posedge clk_i);
		wb(1'b0, REG_MODE, 32'h0);
		`CHK(wb_q[11:0], 12'h030)
		ctrl.cmd(1'b0, 3'h3, 12'h0ab, 2'h0, 4'h0, 32'h0);
		rd(2'h0, 8'h00, 4'h0, 3, 1, 1'b0, 32'h11111111);
		wb(1'b1, REG_MODE, 32'h032);
		rd(2'h0, 8'h01, 4'h0, 3, 4, 1'b0, 32'h0);
		// burst stop on the third beat: that beat still runs, the fourth never does
		ctrl.cmd(1'b0, 3'h5, 12'h001, 2'h0, 4'h0, 32'h0);
		ctrl.cmd(1'b0, 3'h6, 12'h000, 2'h0, 4'h0, 32'h0);
		#1 `CHK(data_lines_o, 32'h22222222)
		@(posedge clk_i);
		#1 `CHK(data_lines_o, 32'h33333333)
		@(posedge clk_i);
		#1 `CHK(data_lines_o, 32'h44444444)
		@(posedge clk_i);
		#1 `CHK(oe_n, 4'hf)
		wb(1'b1, REG_MODE, 32'h03a);
		rd(2'h0, 8'h01, 4'h0, 3, 4, 1'b1, 32'h0);
		wb(1'b1, REG_MODE, 32'h232);
		ctrl.cmd(1'b0, 3'h4, 12'h000, 2'h0, 4'h0, 32'ha5a5a5a5);
		wb(1'b1, REG_MODE, 32'h030);
		rd(2'h0, 8'h01, 4'h0, 3, 1, 1'b0, 32'h22222222);
		rd(2'h0, 8'h00, 4'h0, 3, 1, 1'b0, 32'ha5a5a5a5);
		$display("mode test done");
		final_report();
	end
endmodule : spci_sdram_dev_tb
